// >>> rtl/asfb_consts.vh
// constants for the api status frame builder: frame layout, types, codes
// assumes inclusion by bare name from the design files
`ifndef ASFB_CONSTS_VH
`define ASFB_CONSTS_VH
`define ASFB_START_DELIM 8'h7E
`define ASFB_CSUM_BASE 8'hFF
`define ASFB_TYPE_RESP 8'h97
`define ASFB_TYPE_EXT 8'h98
`define ASFB_EXT_SECURE_BIT 3
`define ASFB_ST_ESTAB 8'h3B
`define ASFB_ST_ENDED 8'h3C
`define ASFB_ST_AUTHFAIL 8'h3D
`define ASFB_CMD_TXFAIL 8'h04
`define ASFB_CMD_ERROR 8'h01
`define ASFB_REASON_PEER 8'h00
`define ASFB_OFS_LEN_HI 5'h01
`define ASFB_OFS_LEN_LO 5'h02
`define ASFB_CMD_MAX 8'h04
`define ASFB_REASON_MAX 8'h04
`define ASFB_OFS_TYPE 5'h03
`define ASFB_OFS_ID 5'h04
`define ASFB_OFS_SRC64 5'h05
`define ASFB_OFS_SRC16 5'h0D
`define ASFB_OFS_CMD 5'h0F
`define ASFB_OFS_STAT 5'h11
`define ASFB_OFS_PARAM 5'h12
`define ASFB_OFS_EADDR 5'h05
`define ASFB_OFS_EOPT 5'h0D
`define ASFB_OFS_ETMO 5'h0E
`define ASFB_RESP_FIXLEN 16'h000F
`define ASFB_EXT_LEN_ESTAB 16'h000D
`define ASFB_EXT_LEN_OTHER 16'h000B
`endif

// >>> rtl/asfb_csum.v
// running checksum over the frame body, offset 3 up to the checksum byte
// assumes the caller pulses clear at frame start and add for each body byte
`timescale 1ns/10ps
`include "asfb_consts.vh"
module asfb_csum
(
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // byte feed
  input wire clear_i,
  input wire add_i,
  input wire [7:0] byte_i,
  // result
  output wire [7:0] csum_o
);
  reg [7:0] sum;
  always @(posedge clk_i)
  begin
    if (sys_rst_i || clear_i)
      sum <= 8'h00;
    else if (add_i)
      sum <= sum + byte_i;
  end
  assign csum_o = `ASFB_CSUM_BASE - sum;
endmodule

// >>> rtl/asfb_frame_builder.v
// api status frame builder: remote command response and extended status frames
// assumes the host port below accepts one byte per cycle when tx_ready_i is high
// Overview of operation
// - a response to a parameter change ends after the status byte, then the checksum.
// - a response to a query appends the current value from offset 18 before the checksum.
// - the last byte is 0xFF minus the low byte of the sum of bytes from offset 3 onward.
// - the response of type 0x97 carries the frame identifier of the request.
// - every frame carries a 16-bit length at offset 1 counting bytes up to the checksum.
// - in unescaped api mode bytes go out as they are, with no escape sequences.
// - extended status frames of type 0x98 go out only while option bit 3 is set.
// - an extended status frame has its status code at offset 4, data, then checksum.
// - a secure-session event 0x3B, 0x3C or 0x3D, taken while idle with no nonzero-id response request, yields an extended status frame when enabled.
// - status 0x3B appends the 64-bit client address, options byte, 16-bit timeout.
// - status 0x3C appends the 64-bit peer address and a reason code 0x00 to 0x04.
// - status 0x3D appends the 64-bit client address and an 8-bit error code.
// - a response goes out only for a nonzero frame identifier.
// - the response status byte is 0x00 to 0x04 for ok, error, bad command, bad value, failure.
// - the response has id at 4, 64-bit source at 5, 16-bit at 13, command at 15, status at 17.
`timescale 1ns/10ps
`include "asfb_consts.vh"
module asfb_frame_builder
#(
  parameter PARAM_MAX = 8
)
(
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // configuration
  input wire [7:0] extended_api_options_i,
  input wire [1:0] api_mode_select_i,
  // remote command response request
  input wire resp_req_i,
  input wire [7:0] resp_id_i,
  input wire [63:0] resp_src64_i,
  input wire [15:0] resp_src16_i,
  input wire [15:0] resp_cmd_i,
  input wire [7:0] resp_status_i,
  input wire resp_is_query_i,
  input wire [PARAM_MAX*8-1:0] resp_param_i,
  input wire [3:0] resp_param_len_i,
  // secure session event request
  input wire sess_req_i,
  input wire [7:0] sess_status_i,
  input wire [63:0] sess_addr_i,
  input wire [7:0] sess_opt_i,
  input wire [15:0] sess_tmo_i,
  input wire [7:0] sess_code_i,
  // byte stream to the host port
  input wire tx_ready_i,
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  output reg tx_last_o,
  // status
  output reg resp_busy_o,
  output reg sess_busy_o,
  output reg escape_req_o
);
  localparam S_IDLE = 2'b00;
  localparam S_SEND = 2'b01;
  localparam S_CSUM = 2'b10;
  // param_max must stay below 15 so the 5-bit offset counter reaches the checksum
  localparam [3:0] PLEN_MAX = PARAM_MAX[3:0];

  reg [1:0] state;
  reg kind_ext;
  reg [4:0] ofs;
  reg [15:0] body_len;
  reg [7:0] f_id;
  reg [63:0] f_addr;
  reg [15:0] f_src16;
  reg [15:0] f_cmd;
  reg [7:0] f_stat;
  reg [7:0] f_opt;
  reg [15:0] f_tmo;
  reg [7:0] f_code;
  reg [PARAM_MAX*8-1:0] f_param;
  reg [3:0] f_plen;
  reg resp_pend;
  reg sess_pend;
  reg [7:0] cur_byte;
  reg [7:0] field_idx;
  wire [7:0] csum;
  wire stall;
  wire body_byte;
  wire last_body;
  wire take_ok;

  assign stall = tx_valid_o && !tx_ready_i;
  // one request at a time, and only once the previous checksum has left
  assign take_ok = (state == S_IDLE) && !resp_pend && !sess_pend && !tx_valid_o;
  assign body_byte = (state == S_SEND) && !stall && (ofs >= `ASFB_OFS_TYPE);
  assign last_body = ({11'h000, ofs} == body_len + {11'h000, `ASFB_OFS_LEN_LO});

  function [7:0] pick_byte;
    input [63:0] word;
    input [2:0] idx;
    begin
      pick_byte = word[63 - idx * 8 -: 8];
    end
  endfunction

  function [15:0] ext_len;
    input [7:0] st;
    begin
      if (st == `ASFB_ST_ESTAB)
        ext_len = `ASFB_EXT_LEN_ESTAB;
      else
        ext_len = `ASFB_EXT_LEN_OTHER;
    end
  endfunction

  asfb_csum u_csum
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(state == S_IDLE),
    .add_i(body_byte),
    .byte_i(cur_byte),
    .csum_o(csum)
  );

  // byte at the current offset, in ascending order
  always @*
  begin
    cur_byte = 8'h00;
    field_idx = 8'h00;
    case (ofs)
      5'h00: cur_byte = `ASFB_START_DELIM;
      `ASFB_OFS_LEN_HI: cur_byte = body_len[15:8];
      `ASFB_OFS_LEN_LO: cur_byte = body_len[7:0];
      `ASFB_OFS_TYPE: cur_byte = kind_ext ? `ASFB_TYPE_EXT : `ASFB_TYPE_RESP;
      `ASFB_OFS_ID: cur_byte = kind_ext ? f_stat : f_id;
      default:
      begin
        if (kind_ext)
        begin
          if (ofs < `ASFB_OFS_EOPT)
            cur_byte = pick_byte(f_addr, ofs[2:0] - 3'h5);
          else if (ofs == `ASFB_OFS_EOPT)
            cur_byte = (f_stat == `ASFB_ST_ESTAB) ? f_opt : f_code;
          else
            cur_byte = (ofs == `ASFB_OFS_ETMO) ? f_tmo[15:8] : f_tmo[7:0];
        end
        else if (ofs < `ASFB_OFS_SRC16)
          cur_byte = pick_byte(f_addr, ofs[2:0] - 3'h5);
        else if (ofs < `ASFB_OFS_CMD)
          cur_byte = (ofs == `ASFB_OFS_SRC16) ? f_src16[15:8] : f_src16[7:0];
        else if (ofs < `ASFB_OFS_STAT)
          cur_byte = (ofs == `ASFB_OFS_CMD) ? f_cmd[15:8] : f_cmd[7:0];
        else if (ofs == `ASFB_OFS_STAT)
          cur_byte = f_stat;
        else
        begin
          field_idx = {3'h0, ofs - `ASFB_OFS_PARAM};
          cur_byte = f_param[field_idx * 8 +: 8];
        end
      end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= S_IDLE;
      kind_ext <= 1'b0;
      ofs <= 5'h00;
      body_len <= 16'h0000;
      f_id <= 8'h00;
      f_addr <= 64'h0;
      f_src16 <= 16'h0000;
      f_cmd <= 16'h0000;
      f_stat <= 8'h00;
      f_opt <= 8'h00;
      f_tmo <= 16'h0000;
      f_code <= 8'h00;
      f_param <= {PARAM_MAX*8{1'b0}};
      f_plen <= 4'h0;
      resp_pend <= 1'b0;
      sess_pend <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
      resp_busy_o <= 1'b0;
      sess_busy_o <= 1'b0;
      escape_req_o <= 1'b0;
    end
    else
    begin
      escape_req_o <= 1'b0;
      // latch requests while idle; a zero id never produces a response
      // holding off while anything is pending keeps the shared fields intact
      if (take_ok && resp_req_i && resp_id_i != 8'h00)
      begin
        resp_pend <= 1'b1;
        f_id <= resp_id_i;
        f_addr <= resp_src64_i;
        f_src16 <= resp_src16_i;
        f_cmd <= resp_cmd_i;
        f_stat <= (resp_status_i > `ASFB_CMD_MAX) ? `ASFB_CMD_ERROR : resp_status_i;
        f_param <= resp_param_i;
        f_plen <= !resp_is_query_i ? 4'h0 :
                  (resp_param_len_i > PARAM_MAX) ? PLEN_MAX : resp_param_len_i;
      end
      else if (take_ok && sess_req_i &&
               extended_api_options_i[`ASFB_EXT_SECURE_BIT] &&
               (sess_status_i == `ASFB_ST_ESTAB || sess_status_i == `ASFB_ST_ENDED ||
                sess_status_i == `ASFB_ST_AUTHFAIL))
      begin
        sess_pend <= 1'b1;
        f_stat <= sess_status_i;
        f_addr <= sess_addr_i;
        f_opt <= sess_opt_i;
        f_tmo <= sess_tmo_i;
        f_code <= (sess_status_i == `ASFB_ST_ENDED && sess_code_i > `ASFB_REASON_MAX) ?
                  `ASFB_REASON_PEER : sess_code_i;
      end
      resp_busy_o <= resp_pend;
      sess_busy_o <= sess_pend;
      case (state)
        S_IDLE:
        begin
          if (resp_pend)
          begin
            kind_ext <= 1'b0;
            body_len <= `ASFB_RESP_FIXLEN + {12'h000, f_plen};
            ofs <= 5'h00;
            state <= S_SEND;
          end
          else if (sess_pend)
          begin
            kind_ext <= 1'b1;
            body_len <= ext_len(f_stat);
            ofs <= 5'h00;
            state <= S_SEND;
          end
        end
        S_SEND:
        begin
          if (!stall)
          begin
            tx_valid_o <= 1'b1;
            tx_data_o <= cur_byte;
            tx_last_o <= 1'b0;
            if (last_body)
              state <= S_CSUM;
            else
              ofs <= ofs + 5'h01;
          end
        end
        S_CSUM:
        begin
          if (!stall)
          begin
            tx_data_o <= csum;
            tx_last_o <= 1'b1;
            state <= S_IDLE;
            if (kind_ext)
              sess_pend <= 1'b0;
            else
              resp_pend <= 1'b0;
          end
        end
        default:
          state <= S_IDLE;
      endcase
      if (state != S_SEND && state != S_CSUM && tx_valid_o && tx_ready_i)
      begin
        tx_valid_o <= 1'b0;
        tx_last_o <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/asfb_chk_sva.sv
// checker for the frame builder byte stream
// assumes the bind below onto asfb_frame_builder
`timescale 1ns/10ps
module asfb_chk
#(
  parameter PARAM_MAX = 8
)
(
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // requests and configuration
  input wire [7:0] extended_api_options_i,
  input wire resp_req_i,
  input wire [7:0] resp_id_i,
  input wire sess_req_i,
  // byte stream and status
  input wire tx_ready_i,
  input wire tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire tx_last_o,
  input wire resp_busy_o,
  input wire sess_busy_o,
  input wire escape_req_o
);
  reg [4:0] ofs;
  reg [7:0] sum;
  wire idle = !resp_busy_o && !sess_busy_o && !tx_valid_o;
  // offset of the byte on offer and running body sum
  always @(posedge clk_i)
  begin
    if (sys_rst_i || (tx_valid_o && tx_ready_i && tx_last_o))
    begin
      ofs <= 5'h00;
      sum <= 8'h00;
    end
    else if (tx_valid_o && tx_ready_i)
    begin
      ofs <= ofs + 5'h01;
      sum <= (ofs > 5'h02) ? sum + tx_data_o : sum;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_data_o) && $stable(tx_last_o)) else $error("byte changed in stall");
  a_no_escape: assert property (escape_req_o == 1'b0) else $error("escape asked");
  a_start_delim: assert property (tx_valid_o && ofs == 5'h00 |-> tx_data_o == 8'h7E)
    else $error("bad start byte");
  a_len_high: assert property (tx_valid_o && ofs == 5'h01 |-> tx_data_o == 8'h00)
    else $error("bad length msb");
  a_type_gate: assert property (tx_valid_o && ofs == 5'h03 |-> tx_data_o == 8'h97
    || (tx_data_o == 8'h98 && extended_api_options_i[3])) else $error("bad type");
  a_csum_value: assert property (tx_valid_o && tx_last_o |-> tx_data_o == 8'hFF - sum)
    else $error("bad checksum");
  a_last_gap: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
    else $error("no gap after frame");
  a_zero_id: assert property (idle && resp_req_i && resp_id_i == 8'h00 && !sess_req_i
    |=> !resp_busy_o ##1 !resp_busy_o && !tx_valid_o) else $error("zero id taken");
  a_sess_gate: assert property (idle && sess_req_i && !extended_api_options_i[3]
    && !resp_req_i |=> !sess_busy_o ##1 !sess_busy_o) else $error("disabled event taken");
  a_frame_span: assert property (tx_valid_o |-> ofs < 19 + PARAM_MAX)
    else $error("frame too long");
endmodule
bind asfb_frame_builder asfb_chk #(.PARAM_MAX(PARAM_MAX)) chk_u (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .extended_api_options_i(extended_api_options_i),
  .resp_req_i(resp_req_i), .resp_id_i(resp_id_i), .sess_req_i(sess_req_i),
  .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_last_o(tx_last_o), .resp_busy_o(resp_busy_o), .sess_busy_o(sess_busy_o),
  .escape_req_o(escape_req_o));

// >>> testbench/asfb_host.sv
// host side sink of the serial port byte stream, may stall
// assumes the bench reads rx_q and frames
`timescale 1ns/10ps
module asfb_host
(
  // clock and pacing
  input wire clk_i,
  input wire slow_i,
  // byte stream
  input wire valid_i,
  input wire [7:0] data_i,
  input wire last_i,
  output reg ready_o = 1'b0
);
  reg [1:0] ph = 2'h0;
  logic [7:0] rx_q[$];
  int frames = 0;
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
    begin
      rx_q.push_back(data_i);
      if (last_i)
        frames++;
    end
    ph <= ph + 2'h1;
    ready_o <= #1 !slow_i || ph != 2'h1;
  end
endmodule

// >>> testbench/asfb_frame_builder_bench.sv
// self-checking bench for the frame builder against a queue model
// assumes asfb_host as the serial port sink
`timescale 1ns/10ps
module asfb_frame_builder_bench;
  reg clk_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
  reg resp_req_i = 1'b0, resp_is_query_i = 1'b0, sess_req_i = 1'b0;
  reg [7:0] extended_api_options_i = 8'h08, resp_id_i = 8'h00, resp_status_i = 8'h00;
  reg [7:0] sess_status_i = 8'h00, sess_opt_i = 8'h00, sess_code_i = 8'h00;
  reg [63:0] resp_src64_i = 64'h0, resp_param_i = 64'h0, sess_addr_i = 64'h0;
  reg [15:0] resp_src16_i = 16'h0, resp_cmd_i = 16'h0, sess_tmo_i = 16'h0;
  reg [3:0] resp_param_len_i = 4'h0;
  reg [31:0] lf = 32'd69013;
  wire tx_ready_i, tx_valid_o, tx_last_o, resp_busy_o, sess_busy_o, escape_req_o;
  wire [7:0] tx_data_o;
  int num_errors = 0, checks = 0, cyc = 0;
  logic [7:0] exp_q[$];
  always #50 clk_i = ~clk_i;
  asfb_frame_builder #(.PARAM_MAX(8)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .extended_api_options_i(extended_api_options_i), .api_mode_select_i(2'h1),
    .resp_req_i(resp_req_i), .resp_id_i(resp_id_i), .resp_src64_i(resp_src64_i),
    .resp_src16_i(resp_src16_i), .resp_cmd_i(resp_cmd_i), .resp_status_i(resp_status_i),
    .resp_is_query_i(resp_is_query_i), .resp_param_i(resp_param_i),
    .resp_param_len_i(resp_param_len_i), .sess_req_i(sess_req_i),
    .sess_status_i(sess_status_i), .sess_addr_i(sess_addr_i), .sess_opt_i(sess_opt_i),
    .sess_tmo_i(sess_tmo_i), .sess_code_i(sess_code_i), .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .resp_busy_o(resp_busy_o), .sess_busy_o(sess_busy_o), .escape_req_o(escape_req_o));
  asfb_host host_u (.clk_i(clk_i), .slow_i(slow), .valid_i(tx_valid_o),
    .data_i(tx_data_o), .last_i(tx_last_o), .ready_o(tx_ready_i));
  function automatic [31:0] lfsr_next(input [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic push_be(input [95:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back(v[i*8+:8]);
  endtask
  // close the model frame, hand over the request, compare what the host took
  task automatic go(input bit fired);
    int t, n;
    logic [7:0] s;
    s = 8'h00;
    t = 0;
    foreach (exp_q[i])
      s += exp_q[i];
    exp_q.push_back(8'hFF - s);
    n = exp_q.size() - 1;
    exp_q = {8'h7E, n[15:8], n[7:0], exp_q};
    slow = lf[3];
    while (!(resp_busy_o | sess_busy_o) && t < 8)
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    resp_req_i = 1'b0;
    sess_req_i = 1'b0;
    t = 0;
    while (host_u.frames == 0 && t < 200)
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    repeat (3) @(posedge clk_i);
    #1;
    chk("frames", 16'(host_u.frames), 16'(fired));
    if (fired)
    begin
      chk("size", 16'(host_u.rx_q.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) chk("byte", host_u.rx_q[i], exp_q[i]);
    end
    host_u.rx_q.delete();
    host_u.frames = 0;
    $display("test done, %0d checks", checks);
  endtask
  task automatic resp(input [7:0] id, st, input q, input [3:0] pl, input bit fired);
    lf = lfsr_next(lf);
    resp_id_i = id;
    resp_status_i = st;
    resp_is_query_i = q;
    resp_param_len_i = pl;
    resp_src64_i = {lf, ~lf};
    resp_src16_i = lf[15:0];
    resp_cmd_i = lf[31:16];
    resp_param_i = {~lf, lf};
    exp_q = {8'h97, id};
    push_be({resp_src64_i, resp_src16_i, resp_cmd_i}, 12);
    exp_q.push_back(st > 8'h04 ? 8'h01 : st);
    for (int i = 0; i < pl && q; i++)
      exp_q.push_back(resp_param_i[i*8+:8]);
    resp_req_i = 1'b1;
    go(fired);
  endtask
  task automatic sess(input [7:0] st, cd, input bit fired);
    lf = lfsr_next(lf);
    sess_status_i = st;
    sess_code_i = cd;
    sess_addr_i = {~lf, lf};
    sess_opt_i = lf[7:0];
    sess_tmo_i = lf[23:8];
    exp_q = {8'h98, st};
    push_be({32'h0, sess_addr_i}, 8);
    if (st == 8'h3B)
      push_be({72'h0, sess_opt_i, sess_tmo_i}, 3);
    else
      exp_q.push_back((st == 8'h3C && cd > 8'h04) ? 8'h00 : cd);
    sess_req_i = 1'b1;
    go(fired);
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk("idle", {tx_valid_o, resp_busy_o, sess_busy_o, escape_req_o}, 16'h0);
    for (int s = 0; s < 6; s++)
      resp(8'h27 + s, s, 1'b0, 4'h0, 1'b1);
    resp(8'h2B, 8'h04, 1'b0, 4'h0, 1'b1);
    resp(8'h2C, 8'h00, 1'b0, 4'h0, 1'b1);
    resp(8'hFF, 8'h00, 1'b1, 4'h8, 1'b1);
    resp(8'h01, 8'h03, 1'b1, 4'h1, 1'b1);
    resp(8'h00, 8'h00, 1'b0, 4'h0, 1'b0);
    for (int c = 0; c < 6; c++)
      sess(8'h3C, c, 1'b1);
    sess(8'h3B, 8'h00, 1'b1);
    sess(8'h3D, lf[7:0], 1'b1);
    sess(8'h3A, 8'h00, 1'b0);
    extended_api_options_i = 8'hF7;
    sess(8'h3B, 8'h00, 1'b0);
    complete_run();
  end
endmodule
